// >>> pkg/rx_irq_pkg.sv
// rx_irq_pkg: register map, field masks and event carrier for the
// per-port receive interrupt logic.
// assumes one register access port shared by all receive ports.
package rx_irq_pkg;

  localparam int MAX_PORTS = 4;

  // register offsets
  localparam logic [7:0] PORT_SELECT_ADDR = 8'h4C;
  localparam logic [7:0] RECV_STATUS_ONE_ADDR = 8'h4D;
  localparam logic [7:0] RECV_STATUS_TWO_ADDR = 8'h4E;
  localparam logic [7:0] ERR_EN_HI_ADDR = 8'hD8;
  localparam logic [7:0] EVT_EN_LO_ADDR = 8'hD9;
  localparam logic [7:0] ERR_ST_HI_ADDR = 8'hDA;
  localparam logic [7:0] EVT_ST_LO_ADDR = 8'hDB;

  // reset values
  localparam logic [7:0] PORT_SELECT_RESET = 8'h10;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // implemented bits; everything else reads zero
  localparam logic [7:0] HI_MASK = 8'h07;
  localparam logic [7:0] LO_MASK = 8'h77;

  // which status bits each receive status read clears
  localparam logic [7:0] CLR_ONE_HI = 8'h03;
  localparam logic [7:0] CLR_ONE_LO = 8'h07;
  localparam logic [7:0] CLR_TWO_HI = 8'h04;
  localparam logic [7:0] CLR_TWO_LO = 8'h70;

  // port select fields
  localparam int SEL_RD_LSB = 0;
  localparam int SEL_WR_LSB = 4;

  // status bit positions
  localparam int BIT_ENC = 2;
  localparam int BIT_SEQ = 1;
  localparam int BIT_CRC = 0;
  localparam int BIT_LEN = 6;
  localparam int BIT_CNT = 5;
  localparam int BIT_OVF = 4;
  localparam int BIT_PAR = 2;
  localparam int BIT_VALID = 1;
  localparam int BIT_LOCK = 0;

  // events from one receive port; pulses except valid and lock (levels)
  typedef struct packed {
    logic enc_err;
    logic seq_err;
    logic crc_err;
    logic line_length_changed;
    logic line_count_changed;
    logic rx_overflow;
    logic parity_err;
    logic port_valid;
    logic lock;
  } rx_event_t;

endpackage

// >>> rtl/rx_port_interrupt_logic.sv
// rx_port_interrupt_logic: per-receive-port interrupt enables, sticky
// status and request outputs, reached through the device register port.
// assumes events come from receiver logic on core_clk (no synchroniser)
// and that the receive status registers themselves live elsewhere.
`timescale 1ns/10ps
`default_nettype none

module rx_port_interrupt_logic
  import rx_irq_pkg::*;
#(
  parameter int NUM_PORTS = MAX_PORTS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire rx_event_t [NUM_PORTS-1:0] rx_evt,
  output logic [NUM_PORTS-1:0] port_irq,
  output logic irq_any
);

  if (NUM_PORTS < 1 || NUM_PORTS > MAX_PORTS) begin : g_bad_ports
    $error("NUM_PORTS must be 1 to 4");
  end

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] sel_q, sel_d;
  logic [7:0] en_hi_q [NUM_PORTS];
  logic [7:0] en_hi_d [NUM_PORTS];
  logic [7:0] en_lo_q [NUM_PORTS];
  logic [7:0] en_lo_d [NUM_PORTS];
  logic [7:0] st_hi_q [NUM_PORTS];
  logic [7:0] st_hi_d [NUM_PORTS];
  logic [7:0] st_lo_q [NUM_PORTS];
  logic [7:0] st_lo_d [NUM_PORTS];
  logic [NUM_PORTS-1:0] valid_prev_q, valid_prev_d;
  logic [NUM_PORTS-1:0] lock_prev_q, lock_prev_d;
  logic primed_q, primed_d;
  logic [NUM_PORTS-1:0] irq_q, irq_d;
  logic [7:0] rdata_q, rdata_d;
  logic hit_q, hit_d;
  logic [1:0] rd_port;
  logic rd_port_ok;

  // read side picks one port; an index past the last port reads zero
  assign rd_port = sel_q[SEL_RD_LSB +: 2];
  assign rd_port_ok = (32'(rd_port) < NUM_PORTS);

  ////////////////////////////////////////////////////////////////////////
  // next-state logic for all ports
  always_comb begin
    logic [7:0] set_hi;
    logic [7:0] set_lo;
    logic [7:0] clr_hi;
    logic [7:0] clr_lo;
    logic wr_this;
    logic rd_this;
    set_hi = 8'h00;
    set_lo = 8'h00;
    clr_hi = 8'h00;
    clr_lo = 8'h00;
    wr_this = 1'b0;
    rd_this = 1'b0;
    sel_d = sel_q;
    primed_d = 1'b1;
    if (reg_wr && reg_addr == PORT_SELECT_ADDR) begin
      sel_d = reg_wdata;
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      en_hi_d[p] = en_hi_q[p];
      en_lo_d[p] = en_lo_q[p];
      // writes reach every port whose write-enable bit is set
      wr_this = reg_wr && sel_q[SEL_WR_LSB + p];
      rd_this = reg_rd && rd_port_ok && (32'(rd_port) == p);
      if (wr_this && reg_addr == ERR_EN_HI_ADDR) begin
        en_hi_d[p] = reg_wdata & HI_MASK;
      end
      if (wr_this && reg_addr == EVT_EN_LO_ADDR) begin
        en_lo_d[p] = reg_wdata & LO_MASK;
      end
      // event capture; level inputs flag on any change once primed
      set_hi = 8'h00;
      set_lo = 8'h00;
      set_hi[BIT_ENC] = rx_evt[p].enc_err;
      set_hi[BIT_SEQ] = rx_evt[p].seq_err;
      set_hi[BIT_CRC] = rx_evt[p].crc_err;
      set_lo[BIT_LEN] = rx_evt[p].line_length_changed;
      set_lo[BIT_CNT] = rx_evt[p].line_count_changed;
      set_lo[BIT_OVF] = rx_evt[p].rx_overflow;
      set_lo[BIT_PAR] = rx_evt[p].parity_err;
      set_lo[BIT_VALID] = primed_q && (rx_evt[p].port_valid != valid_prev_q[p]);
      set_lo[BIT_LOCK] = primed_q && (rx_evt[p].lock != lock_prev_q[p]);
      valid_prev_d[p] = rx_evt[p].port_valid;
      lock_prev_d[p] = rx_evt[p].lock;
      // reads of the receive status registers clear their flag groups
      clr_hi = 8'h00;
      clr_lo = 8'h00;
      if (rd_this && reg_addr == RECV_STATUS_ONE_ADDR) begin
        clr_hi = CLR_ONE_HI;
        clr_lo = CLR_ONE_LO;
      end
      if (rd_this && reg_addr == RECV_STATUS_TWO_ADDR) begin
        clr_hi = CLR_TWO_HI;
        clr_lo = CLR_TWO_LO;
      end
      // set beats clear so an event in the read cycle is kept
      st_hi_d[p] = ((st_hi_q[p] & ~clr_hi) | set_hi) & HI_MASK;
      st_lo_d[p] = ((st_lo_q[p] & ~clr_lo) | set_lo) & LO_MASK;
      // request follows next flags so it drops with the clearing read
      irq_d[p] = |(st_hi_d[p] & en_hi_d[p])
        | |(st_lo_d[p] & en_lo_d[p]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data mux; registered so the bus sees flop outputs
  always_comb begin
    rdata_d = rdata_q;
    hit_d = 1'b0;
    if (reg_rd) begin
      rdata_d = 8'h00;
      hit_d = 1'b1;
      case (reg_addr)
        PORT_SELECT_ADDR: rdata_d = sel_q;
        ERR_EN_HI_ADDR: if (rd_port_ok) rdata_d = en_hi_q[rd_port];
        EVT_EN_LO_ADDR: if (rd_port_ok) rdata_d = en_lo_q[rd_port];
        ERR_ST_HI_ADDR: if (rd_port_ok) rdata_d = st_hi_q[rd_port];
        EVT_ST_LO_ADDR: if (rd_port_ok) rdata_d = st_lo_q[rd_port];
        default: hit_d = 1'b0; // status one/two answered by their owner
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sel_q <= PORT_SELECT_RESET;
      primed_q <= 1'b0;
      valid_prev_q <= '0;
      lock_prev_q <= '0;
      irq_q <= '0;
      rdata_q <= 8'h00;
      hit_q <= 1'b0;
      for (int p = 0; p < NUM_PORTS; p++) begin
        en_hi_q[p] <= ENABLE_RESET;
        en_lo_q[p] <= ENABLE_RESET;
        st_hi_q[p] <= STATUS_RESET;
        st_lo_q[p] <= STATUS_RESET;
      end
    end else begin
      sel_q <= sel_d;
      primed_q <= primed_d;
      valid_prev_q <= valid_prev_d;
      lock_prev_q <= lock_prev_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
      hit_q <= hit_d;
      for (int p = 0; p < NUM_PORTS; p++) begin
        en_hi_q[p] <= en_hi_d[p];
        en_lo_q[p] <= en_lo_d[p];
        st_hi_q[p] <= st_hi_d[p];
        st_lo_q[p] <= st_lo_d[p];
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_hit = hit_q;
  assign port_irq = irq_q;
  assign irq_any = |irq_q;

  ////////////////////////////////////////////////////////////////////////
  // checks, watching port 0
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence rd_one_s;
    reg_rd && reg_addr == RECV_STATUS_ONE_ADDR && rd_port == 2'h0;
  endsequence

  sequence rd_two_s;
    reg_rd && reg_addr == RECV_STATUS_TWO_ADDR && rd_port == 2'h0;
  endsequence

  sequence quiet_hi_s;
    rx_evt[0].enc_err == 1'b0 && rx_evt[0].seq_err == 1'b0 && rx_evt[0].crc_err == 1'b0;
  endsequence

  enable_reset_a: assert property (@(posedge core_clk) disable iff (1'b0)
    !rst_n |=> en_hi_q[0] == 8'h00 && en_lo_q[0] == 8'h00 && port_irq == '0)
    else $error("enables not zero after reset");

  port_route_a: assert property (
    reg_wr && reg_addr == ERR_EN_HI_ADDR && !sel_q[SEL_WR_LSB] |=> $stable(en_hi_q[0]))
    else $error("write reached an unselected port");

  enc_flag_a: assert property (
    rx_evt[0].enc_err |=> st_hi_q[0][BIT_ENC] && (!en_hi_q[0][BIT_ENC] || port_irq[0]))
    else $error("encoding error not flagged or not raised");

  seq_clear_a: assert property (
    rd_one_s ##0 quiet_hi_s |=> !st_hi_q[0][BIT_SEQ] && !st_hi_q[0][BIT_CRC])
    else $error("sequence or crc flag not cleared by status one read");

  enc_clear_a: assert property (
    rd_two_s ##0 !rx_evt[0].enc_err |=> !st_hi_q[0][BIT_ENC])
    else $error("encoding flag not cleared by status two read");

  crc_keep_a: assert property (
    rd_two_s ##0 st_hi_q[0][BIT_CRC] |=> st_hi_q[0][BIT_CRC])
    else $error("crc flag cleared by wrong read");

  lo_two_clear_a: assert property (
    rd_two_s ##0 (rx_evt[0].line_length_changed == 1'b0) |=> st_lo_q[0][BIT_LEN] == 1'b0)
    else $error("line length flag not cleared by status two read");

  lock_change_a: assert property (
    primed_q && rx_evt[0].lock != lock_prev_q[0] |=> st_lo_q[0][BIT_LOCK] ##1
    (st_lo_q[0][BIT_LOCK] || ($past(reg_rd) && $past(rd_port) == 2'h0)))
    else $error("lock change not flagged");

  reserved_zero_a: assert property (
    (st_hi_q[0] & ~HI_MASK) == 8'h00 && (en_lo_q[0] & ~LO_MASK) == 8'h00)
    else $error("reserved bits set");

  irq_gate_a: assert property (
    (st_lo_q[0] & en_lo_q[0]) == 8'h00 && (st_hi_q[0] & en_hi_q[0]) == 8'h00
    |-> !port_irq[0])
    else $error("request without an enabled flag");

  status_read_a: assert property (
    reg_rd && reg_addr == ERR_ST_HI_ADDR && rd_port == 2'h0
    |=> reg_rdata == $past(st_hi_q[0]) && reg_hit)
    else $error("status read returned wrong port data");

  // further checks on port 0: event flags, group clears, register writes
  seq_flag_a: assert property (
    rx_evt[0].seq_err |=> st_hi_q[0][BIT_SEQ])
    else $error("sequence error not flagged");

  crc_flag_a: assert property (
    rx_evt[0].crc_err |=> st_hi_q[0][BIT_CRC])
    else $error("crc error not flagged");

  len_flag_a: assert property (
    rx_evt[0].line_length_changed |=> st_lo_q[0][BIT_LEN])
    else $error("line length change not flagged");

  cnt_flag_a: assert property (
    rx_evt[0].line_count_changed |=> st_lo_q[0][BIT_CNT])
    else $error("line count change not flagged");

  ovf_flag_a: assert property (
    rx_evt[0].rx_overflow |=> st_lo_q[0][BIT_OVF])
    else $error("receive overflow not flagged");

  parity_flag_a: assert property (
    rx_evt[0].parity_err |=> st_lo_q[0][BIT_PAR] && (!en_lo_q[0][BIT_PAR] || port_irq[0]))
    else $error("parity error not flagged or not raised");

  valid_change_a: assert property (
    primed_q && rx_evt[0].port_valid != valid_prev_q[0] |=> st_lo_q[0][BIT_VALID])
    else $error("port valid change not flagged");

  par_clear_a: assert property (
    rd_one_s ##0 !rx_evt[0].parity_err |=> !st_lo_q[0][BIT_PAR])
    else $error("parity flag not cleared by status one read");

  par_keep_a: assert property (
    rd_two_s ##0 st_lo_q[0][BIT_PAR] |=> st_lo_q[0][BIT_PAR])
    else $error("parity flag cleared by wrong read");

  status_ro_a: assert property (
    (reg_wr && reg_addr == ERR_ST_HI_ADDR) ##0 quiet_hi_s |=> $stable(st_hi_q[0]))
    else $error("status changed by a register write");

  enable_write_a: assert property (
    reg_wr && reg_addr == EVT_EN_LO_ADDR && sel_q[SEL_WR_LSB]
    |=> en_lo_q[0] == ($past(reg_wdata) & LO_MASK))
    else $error("low enable write not stored with reserved bits masked");

  select_write_a: assert property (
    reg_wr && reg_addr == PORT_SELECT_ADDR |=> sel_q == $past(reg_wdata))
    else $error("port select write not stored");

  irq_raise_a: assert property (
    (st_hi_q[0] & en_hi_q[0]) != 8'h00 || (st_lo_q[0] & en_lo_q[0]) != 8'h00 |-> port_irq[0])
    else $error("enabled flag without a request");

endmodule

`default_nettype wire

// >>> sim/testbench.sv
// testbench: drives the register port and the per-port receive events of
// rx_port_interrupt_logic directly and compares against expected values.
// assumes the default of four ports and the register map of rx_irq_pkg.
`timescale 1ns/10ps
`default_nettype none

module testbench
  import rx_irq_pkg::*;
;
  logic core_clk;
  logic rst_n;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic reg_hit;
  logic [35:0] ev_bits;
  rx_event_t [3:0] evt;
  logic [3:0] port_irq;
  logic irq_any;
  int err_count;
  int comparisons;
  int cycles;
  logic [7:0] d;
  logic h;
  logic [7:0] en;
  logic [7:0] m;
  // status bit of each event, in carrier order from the top field down
  int bit_pos [9] = '{2, 1, 0, 6, 5, 4, 2, 1, 0};
  logic [7:0] clr_addr [9] = '{8'h4E, 8'h4D, 8'h4D, 8'h4E, 8'h4E, 8'h4E, 8'h4D, 8'h4D, 8'h4D};

  assign evt = ev_bits;

  rx_port_interrupt_logic #(.NUM_PORTS(4)) i_dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_hit(reg_hit),
    .rx_evt(evt),
    .port_irq(port_irq),
    .irq_any(irq_any)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard; a run of a few hundred cycles is expected
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count = err_count + 1;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks; strobes last one cycle, inputs move on falling edges
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic hit);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    v = reg_rdata;
    hit = reg_hit;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    logic hit;
    rd(a, v, hit);
    check(v, exp);
  endtask

  // request lines are compared one cycle later to let a register update land
  task automatic chk_irq(input logic [3:0] e);
    @(negedge core_clk);
    check({3'h0, irq_any, port_irq}, {3'h0, |e, e});
  endtask

  // pulse fields rise for one cycle; valid and lock only flip
  task automatic pulse(input int p, input int k);
    @(negedge core_clk);
    ev_bits[p*9+k] = ~ev_bits[p*9+k];
    @(negedge core_clk);
    if (k > 1) begin
      ev_bits[p*9+k] = 1'b0;
    end
  endtask

  task automatic complete_run();
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ev_bits = '0;
    err_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    // reset values, then reserved bits and read-only status
    chk_rd(ERR_EN_HI_ADDR, 8'h00);
    chk_rd(EVT_EN_LO_ADDR, 8'h00);
    chk_rd(ERR_ST_HI_ADDR, 8'h00);
    chk_rd(EVT_ST_LO_ADDR, 8'h00);
    chk_rd(PORT_SELECT_ADDR, 8'h10);
    wr(ERR_EN_HI_ADDR, 8'hFF);
    wr(EVT_EN_LO_ADDR, 8'hFF);
    chk_rd(ERR_EN_HI_ADDR, 8'h07);
    chk_rd(EVT_EN_LO_ADDR, 8'h77);
    // receive status one belongs to another block, so no hit from here
    rd(RECV_STATUS_ONE_ADDR, d, h);
    check({7'h00, h}, 8'h00);
    rd(EVT_EN_LO_ADDR, d, h);
    check({7'h00, h}, 8'h01);
    wr(ERR_ST_HI_ADDR, 8'hFF);
    wr(EVT_ST_LO_ADDR, 8'hFF);
    chk_rd(ERR_ST_HI_ADDR, 8'h00);
    chk_rd(EVT_ST_LO_ADDR, 8'h00);
    rd(8'hD7, d, h);
    check(d, 8'h00);
    check({7'h00, h}, 8'h00);
    wr(ERR_EN_HI_ADDR, 8'h00);
    wr(EVT_EN_LO_ADDR, 8'h00);
    // each event: latch while masked, raise when enabled, clear by the right read
    for (int i = 0; i < 9; i++) begin
      en = (i < 3) ? ERR_EN_HI_ADDR : EVT_EN_LO_ADDR;
      m = 8'h01 << bit_pos[i];
      pulse(0, 8 - i);
      chk_irq(4'h0);
      chk_rd(en + 8'h02, m);
      wr(en, m);
      chk_irq(4'h1);
      rd(clr_addr[i] ^ 8'h03, d, h);
      chk_rd(en + 8'h02, m);
      rd(clr_addr[i], d, h);
      chk_rd(en + 8'h02, 8'h00);
      chk_irq(4'h0);
      wr(en, 8'h00);
    end
    // per-port copies behind the shared port select
    wr(PORT_SELECT_ADDR, 8'h21);
    wr(ERR_EN_HI_ADDR, 8'h05);
    chk_rd(ERR_EN_HI_ADDR, 8'h05);
    pulse(1, 6);
    chk_irq(4'h2);
    wr(PORT_SELECT_ADDR, 8'h10);
    chk_rd(ERR_EN_HI_ADDR, 8'h00);
    chk_rd(ERR_ST_HI_ADDR, 8'h00);
    wr(PORT_SELECT_ADDR, 8'h01);
    wr(ERR_EN_HI_ADDR, 8'h02);
    chk_rd(ERR_ST_HI_ADDR, 8'h01);
    chk_rd(ERR_EN_HI_ADDR, 8'h05);
    rd(RECV_STATUS_ONE_ADDR, d, h);
    chk_irq(4'h0);
    // reset in mid-run with a live request; held valid and lock levels must not flag
    pulse(1, 6);
    chk_irq(4'h2);
    @(negedge core_clk);
    rst_n = 1'b0;
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    chk_irq(4'h0);
    chk_rd(PORT_SELECT_ADDR, 8'h10);
    chk_rd(EVT_ST_LO_ADDR, 8'h00);
    wr(PORT_SELECT_ADDR, 8'h01);
    chk_rd(ERR_EN_HI_ADDR, 8'h00);
    chk_rd(ERR_ST_HI_ADDR, 8'h00);
    complete_run();
  end

endmodule
`default_nettype wire
